// file: rtl/uart_addr_pkg.sv
package uart_addr_pkg;

  // serial mode encodings from the serial control register
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8BIT = 2'h1;

  // bit timing: core clock rate and default line rate
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_RATE = 115_200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;

  // receive buffer depth
  localparam int FIFO_DEPTH = 4;

  // line level values
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_START = 1'b0;

  // one received character: ninth bit and data byte
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } rx_word_t;

  localparam int RX_WORD_W = $bits(rx_word_t);

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP = 3'b100,
    RX_PUSH = 3'b101
  } rx_state_t;

endpackage

// file: rtl/uart_address_recognition.sv
// Contract
// [R1] framing error flag stays set until software clear or reset
// [R2] with framing detection enabled, receive done rises at the stop bit
// [R3] address recognition is on exactly when multiproc_enable is set and the serial mode is not mode 0
// [R4] with recognition on, only frames matching our address raise receive done
// [R5] mode 1 with recognition: match and valid stop bit both needed
// [R6] in mode 0 multiproc_enable has no effect
// [R7] given address or broadcast address match both count as ours
// [R8] given address: own byte compared only where mask bit is one
// [R9] software sets mask to all ones to compare every own-address bit
// [R10] broadcast address is own OR mask; zero bits are don't care
// [R11] systems typically use all ones as broadcast address
// [R12] a master reaching all slaves sends the all-ones address
// [R13] a low sampled stop bit sets the framing error flag
// [R14] with multiproc off, every completed frame raises receive done
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo, one packed struct of state
module rx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t cur;
  fifo_state_t next_cur;
  logic do_push;
  logic do_pop;

  // honest flags straight from the occupancy count
  assign in_ready_o = (cur.count != FULL_COUNT);
  assign out_valid_o = (cur.count != '0);
  assign out_data_o = cur.mem[cur.rd_ptr];
  assign do_push = in_valid_i && in_ready_o;
  assign do_pop = out_valid_o && out_ready_i;

  // pointer wrap is explicit so non power of two depths work
  always_comb begin
    next_cur = cur;
    if (do_push) begin
      next_cur.mem[cur.wr_ptr] = in_data_i;
      next_cur.wr_ptr = (cur.wr_ptr == LAST_PTR) ? '0 : cur.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_cur.rd_ptr = (cur.rd_ptr == LAST_PTR) ? '0 : cur.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      next_cur.count = cur.count + 1'b1;
    end else if (do_pop && !do_push) begin
      next_cur.count = cur.count - 1'b1;
    end
  end

  // storage is not reset, only the pointers and count
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cur.mem <= next_cur.mem;
      cur.wr_ptr <= '0;
      cur.rd_ptr <= '0;
      cur.count <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// serial receiver with address filtering and sticky error flag
module uart_address_recognition
  import uart_addr_pkg::*;
#(
  parameter int BIT_CYCLES_P = BIT_CYCLES,
  parameter int DEPTH_P = FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic rxd_i,
  input wire logic [1:0] serial_mode_i,
  input wire logic multiproc_enable_i,
  input wire logic fe_detect_enable_i,
  input wire logic [7:0] own_address_byte_i,
  input wire logic [7:0] address_mask_byte_i,
  input wire logic receive_done_clear_i,
  input wire logic framing_error_clear_i,
  output logic receive_done_flag_o,
  output logic framing_error_flag_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output rx_word_t rx_word_o
);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES_P - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES_P / 2 - 1);

  typedef struct packed {
    rx_state_t st;
    logic [15:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shift;
    logic ninth;
    logic sync1;
    logic sync2;
    logic after_stop;
    logic done;
    logic fe;
  } rx_regs_t;

  rx_regs_t cur;
  rx_regs_t next_cur;
  rx_word_t push_word;
  logic push_valid;
  logic push_ready;
  logic filter_on;
  logic need_stop;
  logic nine_bit;
  logic bit_end;

  // given address or broadcast address; zero mask bits and zero bits of the broadcast pattern are don't care
  function automatic logic addr_match(input logic [7:0] addr, input logic [7:0] own,
                                      input logic [7:0] mask);
    logic [7:0] bcast;
    bcast = own | mask; // [R10]
    addr_match = (((addr ^ own) & mask) == 8'h00) || // [R8]
                 (((addr ^ bcast) & bcast) == 8'h00); // [R7]
  endfunction

  // mode 0 ignores the multiproc bit entirely
  assign filter_on = multiproc_enable_i && (serial_mode_i != MODE_SHIFT); // [R3] [R6]
  assign nine_bit = serial_mode_i[1];
  // the stop bit must be seen before deciding when errors are watched or mode 1 filters
  assign need_stop = fe_detect_enable_i || (filter_on && serial_mode_i == MODE_8BIT); // [R2] [R5]
  assign bit_end = (cur.cnt == BIT_LAST);

  // acceptance of the finished character, evaluated where it is decided
  function automatic logic accept(input logic filt, input logic [1:0] mode,
                                  input logic match, input logic ninth, input logic stop_ok);
    if (!filt) begin
      accept = 1'b1; // [R14]
    end else if (mode == MODE_8BIT) begin
      accept = match && stop_ok; // [R5]
    end else begin
      accept = match && ninth; // [R4]
    end
  endfunction

  assign push_valid = (cur.st == RX_PUSH);
  assign push_word = '{ninth: cur.ninth, data: cur.shift};

  // receive sequencer; flags are sticky and a set beats a clear in the same cycle
  always_comb begin
    logic matched;
    logic stop_ok;
    matched = addr_match(cur.shift, own_address_byte_i, address_mask_byte_i);
    stop_ok = (cur.sync2 == LINE_IDLE);
    next_cur = cur;
    next_cur.sync1 = rxd_i;
    next_cur.sync2 = cur.sync1;
    next_cur.cnt = bit_end ? 16'h0000 : cur.cnt + 16'h0001;
    if (receive_done_clear_i) begin
      next_cur.done = 1'b0;
    end
    if (framing_error_clear_i) begin
      next_cur.fe = 1'b0; // [R1]
    end
    case (cur.st)
      RX_IDLE: begin
        next_cur.cnt = 16'h0000;
        if (cur.sync2 == LINE_START) begin
          next_cur.st = RX_START;
        end
      end
      RX_START: begin
        // mid-bit check filters glitches on the idle line
        if (cur.cnt == HALF_LAST) begin
          next_cur.cnt = 16'h0000;
          next_cur.bitn = 3'h0;
          next_cur.st = (cur.sync2 == LINE_START) ? RX_DATA : RX_IDLE;
        end
      end
      RX_DATA: begin
        if (bit_end) begin
          next_cur.shift = {cur.sync2, cur.shift[7:1]};
          next_cur.bitn = cur.bitn + 3'h1;
          next_cur.ninth = 1'b0;
          if (cur.bitn == 3'h7) begin
            if (nine_bit) begin
              next_cur.st = RX_NINTH;
            end else if (need_stop) begin
              next_cur.st = RX_STOP; // [R2]
            end else begin
              // early decision at last data bit; no address byte filtering here
              next_cur.st = RX_PUSH;
              next_cur.after_stop = 1'b0;
            end
          end
        end
      end
      RX_NINTH: begin
        if (bit_end) begin
          next_cur.ninth = cur.sync2;
          if (need_stop) begin
            next_cur.st = RX_STOP; // [R2]
          end else if (accept(filter_on, serial_mode_i, matched, cur.sync2, 1'b1)) begin
            next_cur.st = RX_PUSH;
            next_cur.after_stop = 1'b0;
          end else begin
            next_cur.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (bit_end) begin
          if (!stop_ok) begin
            next_cur.fe = 1'b1; // [R13] [R1]
          end
          // a frame already delivered early only needs its stop checked
          if (need_stop &&
              accept(filter_on, serial_mode_i, matched, cur.ninth, stop_ok)) begin
            next_cur.st = RX_PUSH;
            next_cur.after_stop = 1'b1;
          end else begin
            next_cur.st = RX_IDLE;
          end
        end
      end
      RX_PUSH: begin
        // waits for buffer room; bit timing keeps running, so a long stall
        // delays the stop sample and can lose the following frame
        if (push_ready) begin
          next_cur.done = 1'b1; // [R4] [R14]
          next_cur.st = cur.after_stop ? RX_IDLE : RX_STOP;
        end
      end
      default: begin
        next_cur.st = RX_IDLE;
      end
    endcase
  end

  // control state to defined values, synchroniser to idle line level
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cur <= '{st: RX_IDLE, cnt: 16'h0000, bitn: 3'h0, shift: 8'h00, ninth: 1'b0,
               sync1: LINE_IDLE, sync2: LINE_IDLE, after_stop: 1'b0, done: 1'b0, fe: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign receive_done_flag_o = cur.done;
  assign framing_error_flag_o = cur.fe;

  // accepted characters queue here for the cpu side
  rx_fifo #(
    .WIDTH(RX_WORD_W),
    .DEPTH(DEPTH_P)
  ) u_rx_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_word),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_word_o)
  );
endmodule

// file: dv/uart_addr_assertions.sv
`timescale 1ns/10ps
// port-level checker for the address filtering receiver
module uart_addr_assertions
  import uart_addr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic rxd_i,
  input wire logic fe_detect_enable_i,
  input wire logic receive_done_clear_i,
  input wire logic framing_error_clear_i,
  input wire logic receive_done_flag_o,
  input wire logic framing_error_flag_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire rx_word_t rx_word_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // flags: sticky, and raised only with their cause
  chk_fe_sticky: assert property (framing_error_flag_o && !framing_error_clear_i |=>
    framing_error_flag_o) else $error("framing flag dropped without clear");
  chk_done_sticky: assert property (receive_done_flag_o && !receive_done_clear_i |=>
    receive_done_flag_o) else $error("receive done dropped without clear");
  chk_done_pushes: assert property ($rose(receive_done_flag_o) |-> rx_valid_o)
    else $error("receive done without a stored word");
  chk_push_done: assert property ($rose(rx_valid_o) |-> receive_done_flag_o)
    else $error("word stored without receive done");
  // stop sample sits mid-bit, so a few edges back the line still shows it
  chk_fe_low_stop: assert property ($rose(framing_error_flag_o) |->
    $past(rxd_i, 3) == LINE_START) else $error("framing flag with high stop");
  // an early decision would land on the last data bit, before any stop check
  chk_done_at_stop: assert property ($rose(receive_done_flag_o) && fe_detect_enable_i &&
    $past(rxd_i, 4) == LINE_START |-> framing_error_flag_o) else $error("done before stop");
  chk_word_held: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o &&
    $stable(rx_word_o)) else $error("stalled word changed");
  chk_reset_clear: assert property (disable iff (1'b0) sys_rst_i |=> !rx_valid_o &&
    !receive_done_flag_o && !framing_error_flag_o) else $error("reset left state");

  // main scenarios reached
  cover property ($rose(receive_done_flag_o));
  cover property ($rose(framing_error_flag_o));
  cover property (rx_valid_o && rx_ready_i);
endmodule

bind uart_address_recognition uart_addr_assertions chk (.core_clk_i, .sys_rst_i, .rxd_i,
  .fe_detect_enable_i, .receive_done_clear_i, .framing_error_clear_i, .receive_done_flag_o,
  .framing_error_flag_o, .rx_valid_o, .rx_ready_i, .rx_word_o);

// file: dv/serial_master_model.sv
`timescale 1ns/10ps
// bus master on the shared serial line; line idles high between frames
module serial_master_model #(
  parameter int BIT_P = 16
) (
  input wire logic core_clk_i,
  output logic rxd_o
);
  initial rxd_o = 1'h1;

  // one frame: start, data lsb first, optional ninth bit, stop
  task automatic send(input logic [7:0] d, input logic nin, has_nin, stp);
    logic [10:0] f;
    f = {stp, nin, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || has_nin) begin
        rxd_o = f[i];
        repeat (BIT_P) @(posedge core_clk_i);
        #1;
      end
    end
    rxd_o = 1'h1;
  endtask
endmodule

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import uart_addr_pkg::*;
;
  localparam int BIT_P = 16;
  logic clk, rst, rdy, mp, fe_en, rd_clr, fe_clr, rd, fe, valid;
  logic [1:0] mode;
  logic [7:0] own, msk;
  wire rxd;
  rx_word_t word;
  logic [8:0] expq[$];
  int bad_count = 0;
  int comparisons = 0;

  serial_master_model #(.BIT_P(BIT_P)) mst (.core_clk_i(clk), .rxd_o(rxd));
  uart_address_recognition #(.BIT_CYCLES_P(BIT_P), .DEPTH_P(4)) uut (
    .core_clk_i(clk), .sys_rst_i(rst), .rxd_i(rxd), .serial_mode_i(mode),
    .multiproc_enable_i(mp), .fe_detect_enable_i(fe_en), .own_address_byte_i(own),
    .address_mask_byte_i(msk), .receive_done_clear_i(rd_clr),
    .framing_error_clear_i(fe_clr), .receive_done_flag_o(rd), .framing_error_flag_o(fe),
    .rx_valid_o(valid), .rx_ready_i(rdy), .rx_word_o(word));

  // 100 MHz core clock
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [8:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // clear done, send one frame, judge done; accepted data joins the queue
  task automatic frame(input logic [7:0] d, input logic stp, acc, nin = 1'h0, chk = 1'h1);
    @(posedge clk);
    #1 rd_clr = 1'h1;
    @(posedge clk);
    #1 rd_clr = 1'h0;
    mst.send(d, nin, mode[1], stp);
    repeat (4) @(posedge clk);
    #1;
    if (chk) check("receive done", rd, acc);
    if (acc) expq.push_back({nin & mode[1], d});
  endtask

  // pop every expected word; a bounded wait covers a receiver held in push
  task automatic drain();
    int n;
    n = 0;
    while (expq.size() > 0) begin
      @(posedge clk);
      #1;
      if (++n > 4000) begin
        bad_count++;
        close_out();
      end
      if (valid === 1'h1) begin
        check("word", word, expq.pop_front());
        rdy = 1'h1;
        @(posedge clk);
        #1 rdy = 1'h0;
      end
    end
    check("empty", valid, 1'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_plain();
    frame(8'h5a, 1'h1, 1'h1);
    frame(8'h3c, 1'h0, 1'h1);
    check("framing", fe, 1'h1);
    frame(8'ha5, 1'h1, 1'h1);
    check("framing", fe, 1'h1);
    #10 fe_clr = 1'h1;
    #10 fe_clr = 1'h0;
    check("framing", fe, 1'h0);
    // done must still be low past the last data bit while the stop bit decides
    fe_en = 1'h1;
    fork
      frame(8'h12, 1'h0, 1'h1);
      begin
        repeat (150) @(posedge clk);
        #1 check("done at stop", rd, 1'h0);
      end
    join
    check("framing", fe, 1'h1);
    fe_en = 1'h0;
    drain();
  endtask

  // given 0101_01xx, broadcast 1111_111x
  task automatic t_filter();
    mp = 1'h1;
    own = 8'h56;
    msk = 8'hfc;
    frame(8'h57, 1'h1, 1'h1);
    frame(8'h5a, 1'h1, 1'h0);
    frame(8'hfe, 1'h1, 1'h1);
    frame(8'h55, 1'h0, 1'h0);
    msk = 8'hff;
    frame(8'h57, 1'h1, 1'h0);
    frame(8'h56, 1'h1, 1'h1);
    frame(8'hff, 1'h1, 1'h1);
    drain();
  endtask

  task automatic t_modes();
    mode = 2'h2;
    frame(8'h56, 1'h1, 1'h1, 1'h1);
    frame(8'h56, 1'h1, 1'h0, 1'h0);
    frame(8'h11, 1'h1, 1'h0, 1'h1);
    mode = MODE_SHIFT;
    frame(8'h11, 1'h1, 1'h1);
    mp = 1'h0;
    mode = 2'h3;
    frame(8'h11, 1'h1, 1'h1, 1'h0);
    drain();
  endtask

  // consumer stalls: the fifth frame waits for room in the full buffer
  task automatic t_fill();
    mode = MODE_8BIT;
    for (int i = 1; i < 6; i++) frame(8'(i), 1'h1, 1'h1, 1'h0, i < 5);
    check("full", valid, 1'h1);
    drain();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    {rdy, mp, fe_en, rd_clr, fe_clr} = 5'h0;
    mode = MODE_8BIT;
    own = 8'h0;
    msk = 8'h0;
    repeat (8) @(posedge clk);
    #1 rst = 1'h0;
    repeat (4) @(posedge clk);
    t_plain();
    t_filter();
    t_modes();
    t_fill();
    close_out();
  end
endmodule
